// ===== design/hub_cfg_pkg.sv
// Purpose: shared constants and types of the hub port configuration bank
// Assumes: 100 MHz clock, 32-bit classic Wishbone register access
// Notes:   register index times four gives the byte address
package hub_cfg_pkg;

  // --------------------------------------------------------------------
  // register indices (byte address = index * 4)
  // --------------------------------------------------------------------
  localparam logic [5:0] CFG_BYTE2_IDX = 6'h07;
  localparam logic [5:0] INDICATOR_REMAP_IDX = 6'h08;
  localparam logic [5:0] FIXED_MASK_IDX = 6'h09;
  localparam logic [5:0] STATUS_IDX = 6'h10;

  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int OC_DLY_LSB = 4;
  localparam int COMPOUND_BIT = 3;
  localparam int RENUMBER_BIT = 3;
  localparam int IND_MODE_LSB = 1;
  localparam int STRING_BIT = 0;
  localparam int STAT_OC_BIT = 0;
  localparam int STAT_COMPOUND_BIT = 1;
  localparam int STAT_STRAP_BIT = 2;

  // --------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------
  localparam logic [1:0] OC_DLY_RST = 2'h0;
  localparam logic COMPOUND_RST = 1'b0;
  localparam logic [3:0] CFG3_RST = 4'h0;
  localparam logic [7:1] FIXED_MASK_RST = 7'h00;

  // --------------------------------------------------------------------
  // codes and timing
  // --------------------------------------------------------------------
  localparam logic [1:0] IND_SPEED_CODE = 2'h1;
  localparam int CLK_MHZ = 100;
  localparam int OC_DLY0_US = 100;
  localparam int OC_DLY1_US = 4000;
  localparam int OC_DLY2_US = 8000;
  localparam int OC_DLY3_US = 16000;
  localparam int OC_DLY0_CYC = OC_DLY0_US * CLK_MHZ;
  localparam int OC_DLY1_CYC = OC_DLY1_US * CLK_MHZ;
  localparam int OC_DLY2_CYC = OC_DLY2_US * CLK_MHZ;
  localparam int OC_DLY3_CYC = OC_DLY3_US * CLK_MHZ;
  localparam int OC_CNT_W = 21;

  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    OC_IDLE = 2'b00,
    OC_COUNT = 2'b01,
    OC_QUAL = 2'b11
  } oc_state_type;

  // what the hub reports to the host, as one bundle
  typedef struct packed {
    logic compound;
    logic renumber;
    logic speed_indication;
    logic indicator_support;
    logic string_support;
    logic [7:0] fixed_mask;
  } hub_report_type;

endpackage

// ===== design/hub_port_config_fields.sv
// Purpose: configuration fields for compound, indicators, strings, fixed
//          ports and over-current qualification of a multi-port hub
// Assumes: synchronous active-high reset, inputs synchronous to clk_i
// Notes:   report and status follow the fields one cycle later
// Function
// - over-current delay field bits 5:4 pick 0.1, 4, 8 or 16 ms
// - outside strap configuration, compound bit 3 of byte 2 set means hub reports compound device
// - in strap configuration any fixed port forces compound report
// - byte 3 bit 3 picks standard numbering (0) or port remap (1)
// - indicator mode bits 2:1, code 01 speed, other codes usb mode
// - indicator support reported only while usb mode is selected
// - byte 3 bit 0 enables string descriptor support
// - mask bit n marks downstream port n non-removable, reported
// - mask bit 0 is reserved and always reads zero
// - in internal default configuration fixed ports come from straps
`timescale 1ns/1ps

module hub_port_config_fields
  import hub_cfg_pkg::*;
#(
  parameter int OC_DLY0 = OC_DLY0_CYC,
  parameter int OC_DLY1 = OC_DLY1_CYC,
  parameter int OC_DLY2 = OC_DLY2_CYC,
  parameter int OC_DLY3 = OC_DLY3_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // configuration source and straps
  input wire logic strap_config_i,
  input wire logic [1:0] fixed_port_straps_i,
  // over-current sense
  input wire logic oc_raw_i,
  output logic oc_qualified_o,
  // host-facing report
  output hub_report_type report_o
);

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [1:0] oc_dly_q, oc_dly_d;
  logic compound_q, compound_d;
  logic [3:0] cfg3_q, cfg3_d;
  logic [7:1] mask_q, mask_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [5:0] idx;
  logic req;
  logic wr_take;
  logic [7:0] strap_mask;
  logic [7:0] eff_mask;
  logic eff_compound;

  assign idx = adr_i[7:2];
  assign req = cyc_i & stb_i;
  // a write lands on the edge where the master sees ack
  assign wr_take = req & we_i & ack_q & sel_i[0];

  // strap decode: port 1, ports 1-2, ports 1-3 for codes 1..3
  always_comb
  begin
    case (fixed_port_straps_i)
      2'h1: strap_mask = 8'h02;
      2'h2: strap_mask = 8'h06;
      2'h3: strap_mask = 8'h0e;
      default: strap_mask = 8'h00;
    endcase
  end

  // straps replace the written mask in internal default configuration
  assign eff_mask = strap_config_i ? strap_mask :
    {mask_q, 1'b0};
  // any strapped fixed port makes the hub compound
  assign eff_compound = strap_config_i ? (|strap_mask) :
    compound_q;

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  // next state of registers, ack and read data
  always_comb
  begin
    oc_dly_d = oc_dly_q;
    compound_d = compound_q;
    cfg3_d = cfg3_q;
    mask_d = mask_q;
    ack_d = req & ~ack_q; // one-cycle ack, dropped after the master sees it
    dat_d = dat_q;
    if (wr_take)
    begin
      case (idx)
        CFG_BYTE2_IDX:
        begin
          oc_dly_d = dat_i[OC_DLY_LSB +: 2];
          compound_d = dat_i[COMPOUND_BIT];
        end
        INDICATOR_REMAP_IDX: cfg3_d = dat_i[3:0];
        FIXED_MASK_IDX: mask_d = dat_i[7:1];
        default: ;
      endcase
    end
    if (req & ~ack_q & ~we_i)
    begin
      dat_d = 32'h0000_0000; // reserved and unmapped bits read zero
      case (idx)
        CFG_BYTE2_IDX:
        begin
          dat_d[OC_DLY_LSB +: 2] = oc_dly_q;
          dat_d[COMPOUND_BIT] = compound_q;
        end
        INDICATOR_REMAP_IDX: dat_d[3:0] = cfg3_q;
        FIXED_MASK_IDX: dat_d[7:0] = {mask_q, 1'b0};
        STATUS_IDX:
        begin
          dat_d[STAT_OC_BIT] = oc_qualified_o;
          dat_d[STAT_COMPOUND_BIT] = eff_compound;
          dat_d[STAT_STRAP_BIT] = strap_config_i;
        end
        default: ;
      endcase
    end
  end

  // register stage of the bus slave
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      oc_dly_q <= OC_DLY_RST;
      compound_q <= COMPOUND_RST;
      cfg3_q <= CFG3_RST;
      mask_q <= FIXED_MASK_RST;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      oc_dly_q <= oc_dly_d;
      compound_q <= compound_d;
      cfg3_q <= cfg3_d;
      mask_q <= mask_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ----------------------------------------------------------------------
  // host report
  // ----------------------------------------------------------------------
  hub_report_type report_q, report_d;
  logic [1:0] ind_mode;

  assign ind_mode = cfg3_q[IND_MODE_LSB +: 2];

  // registered so the descriptor logic never sees a half-written byte
  always_comb
  begin
    report_d.compound = eff_compound;
    report_d.renumber = cfg3_q[RENUMBER_BIT];
    report_d.speed_indication = (ind_mode == IND_SPEED_CODE);
    report_d.indicator_support = (ind_mode != IND_SPEED_CODE);
    report_d.string_support = cfg3_q[STRING_BIT];
    report_d.fixed_mask = eff_mask;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      report_q <= '0;
    else
      report_q <= report_d;
  end

  assign report_o = report_q;

  // ----------------------------------------------------------------------
  // over-current qualification
  // ----------------------------------------------------------------------
  oc_state_type oc_q, oc_d;
  logic [OC_CNT_W-1:0] cnt_q, cnt_d;
  logic [OC_CNT_W-1:0] dly_sel;

  // delay choice; a change mid-count applies at once, a trade for area
  always_comb
  begin
    case (oc_dly_q)
      2'h0: dly_sel = OC_CNT_W'(OC_DLY0);
      2'h1: dly_sel = OC_CNT_W'(OC_DLY1);
      2'h2: dly_sel = OC_CNT_W'(OC_DLY2);
      default: dly_sel = OC_CNT_W'(OC_DLY3);
    endcase
  end

  // any drop of the raw flag restarts the wait, so glitches are ignored
  always_comb
  begin
    oc_d = oc_q;
    cnt_d = cnt_q;
    case (oc_q)
      OC_IDLE:
      begin
        cnt_d = '0;
        if (oc_raw_i)
          oc_d = OC_COUNT;
      end
      OC_COUNT:
      begin
        if (!oc_raw_i)
          oc_d = OC_IDLE;
        else if (cnt_q >= dly_sel - OC_CNT_W'(1))
          oc_d = OC_QUAL;
        else
          cnt_d = cnt_q + OC_CNT_W'(1);
      end
      OC_QUAL:
      begin
        if (!oc_raw_i)
          oc_d = OC_IDLE;
      end
      default: oc_d = OC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      oc_q <= OC_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      oc_q <= oc_d;
      cnt_q <= cnt_d;
    end
  end

  assign oc_qualified_o = (oc_q == OC_QUAL);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  oc_delay_exact_a: assert property (
    $rose(oc_qualified_o) |-> $past(cnt_q) == dly_sel - OC_CNT_W'(1))
    else $error("over-current qualified at wrong count");

  oc_glitch_drop_a: assert property (
    !oc_raw_i |=> !oc_qualified_o)
    else $error("over-current held without raw flag");

  oc_short_delay_a: assert property (
    oc_dly_q == 2'h0 && dly_sel > OC_CNT_W'(2) && oc_q == OC_IDLE
    && oc_raw_i |=> !oc_qualified_o [*2])
    else $error("over-current qualified too soon");

  strap_compound_a: assert property (
    strap_config_i && fixed_port_straps_i != 2'h0
    |=> report_o.compound && report_o.fixed_mask != 8'h00)
    else $error("strapped fixed port without compound report");

  soft_compound_a: assert property (
    !strap_config_i && !$past(strap_config_i)
    |-> report_o.compound == $past(compound_q))
    else $error("compound report differs from register");

  indicator_support_a: assert property (
    !$past(rst_i) |-> report_o.indicator_support ==
    ($past(cfg3_q[IND_MODE_LSB +: 2]) inside {2'h0, 2'h2, 2'h3})
    && report_o.indicator_support != report_o.speed_indication)
    else $error("indicator support reported in speed mode");

  indicator_mode_a: assert property (
    wr_take && idx == INDICATOR_REMAP_IDX
    && dat_i[IND_MODE_LSB +: 2] == IND_SPEED_CODE
    |=> ##1 report_o.speed_indication && !report_o.indicator_support)
    else $error("speed mode code not reported");

  mask_bit0_a: assert property (
    report_o.fixed_mask[0] == 1'b0
    && !(ack_o && idx == FIXED_MASK_IDX && dat_o[0]))
    else $error("reserved mask bit seen as one");

  mask_write_a: assert property (
    wr_take && idx == FIXED_MASK_IDX && !strap_config_i
    ##1 !strap_config_i |=> report_o.fixed_mask[7:1] == $past(dat_i[7:1], 2))
    else $error("written fixed mask not reported");

  cfg3_write_a: assert property (
    wr_take && idx == INDICATOR_REMAP_IDX
    |=> ##1 report_o.renumber == $past(dat_i[RENUMBER_BIT], 2)
    && report_o.string_support == $past(dat_i[STRING_BIT], 2))
    else $error("byte 3 write not reported");

  reserved_read_a: assert property (
    ack_o && !we_i && idx == CFG_BYTE2_IDX
    |-> dat_o[2:0] == 3'h0 && dat_o[31:6] == 26'h0)
    else $error("reserved bits read nonzero");

  bus_ack_a: assert property (
    req && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle after request");

  oc_rise_c: cover property ($rose(oc_qualified_o));
  strap_c: cover property (strap_config_i && report_o.compound);
  mask_wr_c: cover property (wr_take && idx == FIXED_MASK_IDX);
  speed_c: cover property (report_o.speed_indication);

endmodule

// ===== bench/host_desc_model.sv
// Purpose: host side that fetches the hub report as its descriptor view
// Assumes: report_i is registered in the hub clock domain
// Notes:   a fetch copies the whole report in one edge
`timescale 1ns/1ps

module host_desc_model
  import hub_cfg_pkg::*;
(
  // clock
  input wire logic clk_i,
  // hub report and fetch request
  input wire hub_report_type report_i,
  input wire logic fetch_i,
  output hub_report_type desc_o
);
  // a fixed-port device answers for itself, so only the hub view is kept
  always_ff @(posedge clk_i)
  begin
    if (fetch_i)
    begin
      desc_o <= report_i;
    end
  end
endmodule

// ===== bench/test_hub_port_config_fields.sv
// Purpose: register and report checks of the hub port configuration bank
// Assumes: ack answers one cycle after a request, shortened delays 4..16
// Notes:   bus calls wait for ack; the watchdog bounds every wait
`timescale 1ns/1ps

module test_hub_port_config_fields
  import hub_cfg_pkg::*;
;
  logic clk_i, rst_i, cyc, stb, we, strap, oc_raw, oc_q, ack, fetch;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [1:0] straps;
  logic [31:0] dat_w, dat_r;
  hub_report_type report, desc;
  int miscompares, total_checks;
  logic [7:0] smask [4] = '{8'h00, 8'h02, 8'h06, 8'h0e};

  hub_port_config_fields #(.OC_DLY0(4), .OC_DLY1(8), .OC_DLY2(12),
    .OC_DLY3(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w),
    .dat_o(dat_r), .ack_o(ack), .strap_config_i(strap),
    .fixed_port_straps_i(straps), .oc_raw_i(oc_raw),
    .oc_qualified_o(oc_q), .report_o(report));

  host_desc_model u_host (.clk_i(clk_i), .report_i(report),
    .fetch_i(fetch), .desc_o(desc));

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one classic cycle; released only at the edge that samples ack
  task automatic wb(input logic w, input logic [5:0] idx,
    input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hf;
    dat_w <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] m,
    input logic [7:0] exp);
    logic [31:0] q;
    wb(1'b0, idx, 8'h00, q);
    check(q & {24'hffffff, m}, {24'h0, exp});
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
  endtask

  // report settles one cycle after the register update
  task automatic rep(input logic [12:0] exp);
    repeat (3) @(posedge clk_i);
    check({19'h0, report}, {19'h0, exp});
  endtask

  task automatic stop_test();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog: whole sequence needs well under 2000 cycles
  initial
  begin
    #100000;
    miscompares++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    {clk_i, cyc, stb, we, strap, oc_raw, fetch} = '0;
    rst_i = 1'b1;
    adr = 8'h00;
    sel = 4'h0;
    straps = 2'b00;
    dat_w = 32'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rep(13'h0200);
    rd(CFG_BYTE2_IDX, 8'hff, 8'h00);
    rd(INDICATOR_REMAP_IDX, 8'hff, 8'h00);
    rd(FIXED_MASK_IDX, 8'hff, 8'h00);
    // reserved bits written too; they must not disturb any field
    wr(CFG_BYTE2_IDX, 8'h3f);
    rd(CFG_BYTE2_IDX, 8'hff, 8'h38);
    wr(FIXED_MASK_IDX, 8'h03);
    rd(FIXED_MASK_IDX, 8'hff, 8'h02);
    rep(13'h1202);
    wr(FIXED_MASK_IDX, 8'hff);
    rep(13'h12fe);
    // every indicator code; full pin set assumed present
    for (int m = 0; m < 4; m++)
    begin
      wr(INDICATOR_REMAP_IDX, {4'hf, m[0], m[1:0], m[1]});
      rd(INDICATOR_REMAP_IDX, 8'hff, {4'h0, m[0], m[1:0], m[1]});
      rep({1'b1, m[0], m == 1, m != 1, m[1], 8'hfe});
    end
    fetch <= 1'b1;
    @(posedge clk_i);
    fetch <= 1'b0;
    rep(13'h1bfe);
    check({19'h0, desc}, 32'h1bfe);
    // strap mode: written mask and compound bit give way to straps
    strap <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      straps <= 2'(s);
      rep({s != 0, 3'b101, 1'b1, smask[s]});
    end
    rd(STATUS_IDX, 8'h04, 8'h04);
    strap <= 1'b0;
    rd(6'h0f, 8'hff, 8'h00);
    wr(STATUS_IDX, 8'hff);
    rd(STATUS_IDX, 8'hff, 8'h02);
    // each delay code: short pulse ignored, long one qualifies
    for (int c = 0; c < 4; c++)
    begin
      wr(CFG_BYTE2_IDX, {2'b00, 2'(c), 4'h8});
      oc_raw <= 1'b1;
      repeat (4 * c + 2) @(posedge clk_i);
      oc_raw <= 1'b0;
      repeat (20) @(posedge clk_i);
      check({31'h0, oc_q}, 32'h0);
      oc_raw <= 1'b1;
      repeat (4 * c + 4) @(posedge clk_i);
      check({31'h0, oc_q}, 32'h0);
      repeat (3) @(posedge clk_i);
      check({31'h0, oc_q}, 32'h1);
      rd(STATUS_IDX, 8'hff, 8'h03);
      oc_raw <= 1'b0;
      repeat (3) @(posedge clk_i);
      check({31'h0, oc_q}, 32'h0);
    end
    stop_test();
  end
endmodule
